// ===== pkg/ocpwm_pkg.sv
// Constants for the output compare / PWM channel
package ocpwm_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CON1 = 8'h00;
  localparam logic [7:0] OFS_CON2 = 8'h04;
  localparam logic [7:0] OFS_PRI = 8'h08;
  localparam logic [7:0] OFS_SEC = 8'h0C;
  localparam logic [7:0] OFS_PER = 8'h10;
  localparam logic [7:0] OFS_CNT = 8'h14;
  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h000C;
  localparam logic [15:0] CON1_WMASK = 16'h3C8F;
  localparam logic [15:0] CON2_WMASK = 16'hF1BF;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_ALL1 = 16'hFFFF;
  // ****************************************
  // Control one fields
  // ****************************************
  localparam int C1_SIDL = 13;
  localparam int C1_TSEL = 10;
  localparam int C1_FEN = 7;
  localparam int C1_FSTAT = 4;
  localparam int C1_TMODE = 3;
  localparam int C1_MODE = 0;
  // ****************************************
  // Control two fields
  // ****************************************
  localparam int C2_FHOLD = 15;
  localparam int C2_FLVL = 14;
  localparam int C2_FFORCE = 13;
  localparam int C2_INV = 12;
  localparam int C2_CASC = 8;
  localparam int C2_TRIG = 7;
  localparam int C2_TSTAT = 6;
  localparam int C2_TRIS = 5;
  localparam int C2_SRC = 0;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] TB_SYS = 3'h7;
  localparam logic [2:0] TB_T1 = 3'h4;
  localparam logic [2:0] TB_T5 = 3'h3;
  localparam logic [2:0] TB_T4 = 3'h2;
  localparam logic [2:0] TB_T3 = 3'h1;
  localparam logic [2:0] TB_T2 = 3'h0;
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_SELF = 5'h1F;
  localparam int FAULT_A_LAST = 4;
  typedef enum logic [2:0] {
    OCPWM_OFF = 3'h0, OCPWM_S_HI = 3'h1, OCPWM_S_LO = 3'h2,
    OCPWM_S_TGL = 3'h3, OCPWM_D_ONE = 3'h4, OCPWM_D_CONT = 3'h5,
    OCPWM_EDGE = 3'h6, OCPWM_CENTER = 3'h7
  } ocpwm_mode_e;
endpackage

// ===== pkg/ocpwm_tb_if.sv
// Carrier between the channel control and its time base counter
`timescale 1ns/1ps
`default_nettype none
interface ocpwm_tb_if;
  logic count_en; // Advance the counter this cycle
  logic clear; // Force counter to zero
  logic [15:0] count; // Present counter value
  logic wrap; // Counter passes all ones to zero
  modport tb (input count_en, input clear, output count, output wrap);
  modport ctl (output count_en, output clear, input count, input wrap);
endinterface
`default_nettype wire

// ===== rtl/ocpwm_pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ocpwm_pin_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_reg; // First stage, read only by second
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // ****************************************
  // Stages; level changes once stages two and three agree
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level = level_reg;
endmodule
`default_nettype wire

// ===== rtl/ocpwm_timebase.sv
// Sixteen-bit channel counter
`timescale 1ns/1ps
`default_nettype none
module ocpwm_timebase
  import ocpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  ocpwm_tb_if.tb tb
);
  logic [15:0] count_reg; // Channel counter
  logic [15:0] count_next;

  // Clear wins, else advance, wrapping all ones to zero
  assign count_next = tb.clear ? VAL_RST :
                      (tb.count_en ? 16'(count_reg + 16'h0001) : count_reg);
  assign tb.count = count_reg;
  assign tb.wrap = tb.count_en && !tb.clear && (count_reg == CNT_ALL1);

  // ****************************************
  // Counter register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= VAL_RST;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ocpwm_channel.sv
// Output compare / PWM channel with Avalon-MM registers
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Period lasts period value plus one counts
// - PWM compare values latch at period end
// - All values zero keeps pin low
// - Secondary above period keeps pin high
// - Stop-in-idle halts channel while processor idles
// - Time base select picks count source
// - Fault enable gates fault pin A or B
// - Fault status set by hardware, center mode
// - Trigger status cleared on secondary match optionally
// - Mode codes: center, edge PWM, disabled
// - Mode 101 toggles continuously on both matches
// - Mode 100 gives one pulse only
// - Single compare modes use primary value only for output and flag
// - Fault hold mode needs software clear in center mode
// - Fault output level drives pin in fault
// - Fault force bit makes pin output
// - Invert bit inverts channel output
// - Cascade bit chains counter to neighbour
// - Trigger select: trigger or counter sync
// - Counter held zero while trigger status clear
// - Tristate bit disconnects pin driver
// - Source select chooses sync/trigger source
// - Free-running counter wraps all ones to zero
// - Trigger waits for event; sync resets counter
// - Interrupt flag on primary match in single modes, secondary match otherwise
module ocpwm_channel
  import ocpwm_pkg::*;
#(
  parameter int CHANNEL_NUM = 1 // Channel number, picks fault pin
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Time base and sync sources
  input wire logic [4:0] timer_tick,
  input wire logic [31:0] sync_sources,
  input wire logic cascade_carry_in,
  output logic cascade_carry_out,
  input wire logic cpu_idle,
  // Fault pins
  input wire logic fault_pin_a,
  input wire logic fault_pin_b,
  // Compare pin and interrupt
  output logic compare_output_pin,
  output logic compare_output_pin_oe,
  output logic channel_interrupt_flag
);
  // ****************************************
  // Functions
  // ****************************************
  // Tick from the selected time base
  function automatic logic tick_pick(input logic [2:0] sel,
                                     input logic [4:0] t);
    logic r;
    r = 1'b0;
    unique case (sel)
      TB_SYS: r = 1'b1;
      TB_T1: r = t[0];
      TB_T2: r = t[1];
      TB_T3: r = t[2];
      TB_T4: r = t[3];
      TB_T5: r = t[4];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Masked register update
  function automatic logic [15:0] wr_mask(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  ocpwm_tb_if tbi (); // Counter link
  logic [15:0] con1_reg; // Control one, writable part
  logic [15:0] con2_reg; // Control two, writable part
  logic [15:0] pri_reg; // Primary compare value
  logic [15:0] sec_reg; // Secondary compare value
  logic [15:0] per_reg; // Time base period value
  logic [15:0] pri_act_reg; // Active PWM primary
  logic [15:0] sec_act_reg; // Active PWM secondary
  logic fstat_reg; // PWM fault status
  logic fstat_next;
  logic tstat_reg; // Trigger status
  logic tstat_next;
  logic fault_reg; // Fault state active
  logic fault_next;
  logic raw_reg; // Waveform before inversion
  logic raw_next;
  logic armed_reg; // Single-shot not yet spent
  logic armed_next;
  logic pin_reg;
  logic oe_reg;
  logic irq_reg;
  logic carry_reg;
  logic wait_reg; // Avalon waitrequest
  logic [31:0] rdata_reg;
  logic fa_lvl; // Filtered fault pins
  logic fb_lvl;

  // ****************************************
  // Field decode
  // ****************************************
  wire ocpwm_mode_e mode = ocpwm_mode_e'(con1_reg[C1_MODE +: 3]);
  wire [2:0] tsel = con1_reg[C1_TSEL +: 3];
  wire [4:0] src = con2_reg[C2_SRC +: 5];
  wire stop_in_idle = con1_reg[C1_SIDL];
  wire fault_input_enable = con1_reg[C1_FEN];
  wire trig_status_clear_mode = con1_reg[C1_TMODE];
  wire fault_hold_mode = con2_reg[C2_FHOLD];
  wire fault_output_level = con2_reg[C2_FLVL];
  wire fault_force_output = con2_reg[C2_FFORCE];
  wire output_invert = con2_reg[C2_INV];
  wire cascade_enable = con2_reg[C2_CASC];
  wire trigger_or_sync_select = con2_reg[C2_TRIG];
  wire output_tristate = con2_reg[C2_TRIS];
  wire is_pwm = (mode == OCPWM_EDGE) || (mode == OCPWM_CENTER);
  wire is_single = (mode == OCPWM_S_HI) || (mode == OCPWM_S_LO) ||
                   (mode == OCPWM_S_TGL);
  wire is_double = !is_single && (mode != OCPWM_OFF);

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr_ack = avs_write && !wait_reg;
  wire wr_con1 = wr_ack && (avs_address == OFS_CON1);
  wire wr_con2 = wr_ack && (avs_address == OFS_CON2);
  wire wr_pri = wr_ack && (avs_address == OFS_PRI);
  wire wr_sec = wr_ack && (avs_address == OFS_SEC);
  wire wr_per = wr_ack && (avs_address == OFS_PER);
  wire [15:0] wd = avs_writedata[15:0];
  wire [15:0] con1_rd = con1_reg | (16'(fstat_reg) << C1_FSTAT);
  wire [15:0] con2_rd = con2_reg | (16'(tstat_reg) << C2_TSTAT);
  wire [15:0] rd_mux = (avs_address == OFS_CON1) ? con1_rd :
                       (avs_address == OFS_CON2) ? con2_rd :
                       (avs_address == OFS_PRI) ? pri_reg :
                       (avs_address == OFS_SEC) ? sec_reg :
                       (avs_address == OFS_PER) ? per_reg :
                       (avs_address == OFS_CNT) ? tbi.count : VAL_RST;

  // ****************************************
  // Time base and sync
  // ****************************************
  wire idle_stop = stop_in_idle && cpu_idle;
  wire src_tick = cascade_enable ? cascade_carry_in :
                  tick_pick(tsel, timer_tick);
  wire en = src_tick && !idle_stop && (mode != OCPWM_OFF);
  wire [15:0] pri_use = is_pwm ? pri_act_reg : pri_reg;
  wire [15:0] sec_use = is_pwm ? sec_act_reg : sec_reg;
  wire per_match = en && (tbi.count == per_reg);
  wire src_valid = (src != SRC_NONE) && (src[4:1] != 4'h8);
  wire sync_evt = src_valid &&
                  ((src == SRC_SELF) ? per_match : sync_sources[src]);
  wire trig_active = trigger_or_sync_select && src_valid;
  wire hold = trig_active && !tstat_reg;
  wire sync_rst = !trigger_or_sync_select && sync_evt;
  assign tbi.count_en = en;
  assign tbi.clear = hold || sync_rst || (mode == OCPWM_OFF);

  // ****************************************
  // Compare matches
  // ****************************************
  wire m_pri = en && (tbi.count == pri_use);
  wire m_sec = en && (tbi.count == sec_use) && is_double;
  wire full_duty = is_pwm && (sec_act_reg > per_reg);
  wire sel_fault = (CHANNEL_NUM <= FAULT_A_LAST) ? fa_lvl : fb_lvl;
  wire fault_in = fault_input_enable && sel_fault;

  // ****************************************
  // Submodules
  // ****************************************
  ocpwm_timebase u_tb (
    .clk(clk),
    .rst(rst),
    .tb(tbi.tb)
  );

  ocpwm_pin_filter u_fa (
    .clk(clk),
    .rst(rst),
    .pin(fault_pin_a),
    .level(fa_lvl)
  );

  ocpwm_pin_filter u_fb (
    .clk(clk),
    .rst(rst),
    .pin(fault_pin_b),
    .level(fb_lvl)
  );

  // ****************************************
  // Waveform next state
  // ****************************************
  always_comb begin
    raw_next = raw_reg;
    armed_next = armed_reg;
    if (wr_con1) begin
      // Rewriting control one restarts the output
      raw_next = (wd[C1_MODE +: 3] == OCPWM_S_LO);
      armed_next = 1'b1;
    end else begin
      unique case (mode)
        OCPWM_OFF: raw_next = 1'b0;
        OCPWM_S_HI: begin
          if (m_pri && armed_reg) begin
            raw_next = 1'b1;
            armed_next = 1'b0;
          end
        end
        OCPWM_S_LO: begin
          if (m_pri && armed_reg) begin
            raw_next = 1'b0;
            armed_next = 1'b0;
          end
        end
        OCPWM_S_TGL: begin
          if (m_pri) begin
            raw_next = !raw_reg;
          end
        end
        OCPWM_D_ONE: begin
          // One pulse, then idle low
          if (armed_reg && m_sec) begin
            raw_next = 1'b0;
            armed_next = 1'b0;
          end else if (armed_reg && m_pri) begin
            raw_next = 1'b1;
          end
        end
        OCPWM_D_CONT: begin
          // Clear wins when both values match together
          if (m_sec) begin
            raw_next = 1'b0;
          end else if (m_pri) begin
            raw_next = 1'b1;
          end
        end
        OCPWM_EDGE, OCPWM_CENTER: begin
          if (full_duty) begin
            raw_next = 1'b1;
          end else if (m_sec) begin
            raw_next = 1'b0;
          end else if (m_pri) begin
            raw_next = 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Fault and trigger status next state
  // ****************************************
  always_comb begin
    fault_next = fault_reg;
    if (fault_in && is_pwm) begin
      fault_next = 1'b1;
    end else if (fault_reg && !fault_in) begin
      // Release after source gone, per hold mode
      if (fault_hold_mode) begin
        fault_next = fstat_reg;
      end else if (per_match) begin
        fault_next = 1'b0;
      end
    end
    // Set wins over any clear
    fstat_next = fstat_reg;
    if (wr_con1 && !wd[C1_FSTAT]) begin
      fstat_next = 1'b0;
    end
    if (!fault_hold_mode && fault_reg && !fault_next) begin
      fstat_next = 1'b0;
    end
    if (fault_in && (mode == OCPWM_CENTER)) begin
      fstat_next = 1'b1;
    end
    tstat_next = tstat_reg;
    if (wr_con2) begin
      tstat_next = wd[C2_TSTAT];
    end
    if (trig_status_clear_mode && en && (tbi.count == sec_use)) begin
      tstat_next = 1'b0;
    end
    if (trig_active && sync_evt) begin
      tstat_next = 1'b1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      con1_reg <= CON1_RST;
      con2_reg <= CON2_RST;
      pri_reg <= VAL_RST;
      sec_reg <= VAL_RST;
      per_reg <= VAL_RST;
    end else begin
      if (wr_con1) con1_reg <= wr_mask(con1_reg, wd, CON1_WMASK);
      if (wr_con2) con2_reg <= wr_mask(con2_reg, wd, CON2_WMASK);
      if (wr_pri) pri_reg <= wd;
      if (wr_sec) sec_reg <= wd;
      if (wr_per) per_reg <= wd;
    end
  end

  // ****************************************
  // Active duty values, loaded at period end
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pri_act_reg <= VAL_RST;
      sec_act_reg <= VAL_RST;
    end else if (per_match || !is_pwm) begin
      pri_act_reg <= pri_reg;
      sec_act_reg <= sec_reg;
    end
  end

  // ****************************************
  // Channel state
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      raw_reg <= 1'b0;
      armed_reg <= 1'b0;
      fault_reg <= 1'b0;
      fstat_reg <= 1'b0;
      tstat_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      armed_reg <= armed_next;
      fault_reg <= fault_next;
      fstat_reg <= fstat_next;
      tstat_reg <= tstat_next;
    end
  end

  // ****************************************
  // Pin, interrupt and carry outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
      irq_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else begin
      pin_reg <= fault_reg ? fault_output_level :
                 (raw_reg ^ output_invert);
      oe_reg <= !output_tristate ||
                (fault_reg && fault_force_output);
      irq_reg <= is_single ? m_pri : m_sec;
      carry_reg <= tbi.wrap;
    end
  end

  // ****************************************
  // Avalon answer: one wait cycle per request
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if ((avs_read || avs_write) && wait_reg) begin
        rdata_reg <= {16'h0000, rd_mux};
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign compare_output_pin = pin_reg;
  assign compare_output_pin_oe = oe_reg;
  assign channel_interrupt_flag = irq_reg;
  assign cascade_carry_out = carry_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  period_wrap_a: assert property (
    per_match && !hold && !trigger_or_sync_select && src == SRC_SELF
    |=> tbi.count == 16'h0000)
    else $error("counter did not restart after period match");
  duty_latch_a: assert property (
    is_pwm && !per_match |=> $stable(sec_act_reg))
    else $error("active duty changed inside period");
  zero_duty_a: assert property (
    is_pwm && !wr_con1 && sec_act_reg == 16'h0000 && per_reg == 16'h0000
    && tbi.count == 16'h0000 && en |=> !raw_reg)
    else $error("zero duty output went high");
  full_duty_a: assert property (
    full_duty && !wr_con1 |=> raw_reg)
    else $error("full duty output not high");
  idle_halt_a: assert property (
    idle_stop && !tbi.clear |=> $stable(tbi.count))
    else $error("counter moved in idle");
  trig_hold_a: assert property (
    hold |=> tbi.count == 16'h0000)
    else $error("counter not held while untriggered");
  fault_level_a: assert property (
    fault_reg |=> pin_reg == $past(fault_output_level))
    else $error("fault level not on pin");
  tristate_pin_a: assert property (
    output_tristate && !fault_reg |=> !oe_reg)
    else $error("pin driven while tristated");
  single_flag_a: assert property (
    is_single && m_pri |=> channel_interrupt_flag)
    else $error("missing flag on primary match");
  cont_toggle_a: assert property (
    mode == OCPWM_D_CONT && m_sec && !wr_con1 |=> !raw_reg)
    else $error("continuous pulse not cleared on secondary");
  bus_answer_a: assert property (
    (avs_read || avs_write) && wait_reg |=> !wait_reg)
    else $error("slave did not answer in one cycle");

  pwm_period_c: cover property (is_pwm && per_match ##[1:50] per_match);
  fault_c: cover property (fault_reg ##1 !fault_reg);
  trigger_c: cover property (hold ##1 tstat_reg);
endmodule
`default_nettype wire

// ===== verification/ocpwm_load.sv
// Load on the compare pin and source of the fault pins
`timescale 1ns/1ps
`default_nettype none
module ocpwm_load (
  // Clock
  input wire logic clk,
  // Fault request from the bench
  input wire logic fault_req,
  // Compare pin as seen by the load
  input wire logic pin,
  input wire logic pin_oe,
  // Fault pins
  output logic fault_a,
  output logic fault_b,
  // Running count of driven high samples
  output var int high_cnt
);
  // ****************************************
  // Fault pins: channel one listens to pin A
  // ****************************************
  assign fault_a = fault_req;
  assign fault_b = 1'b0;
  // ****************************************
  // Load: a released pin reads low through its pull-down
  // ****************************************
  initial high_cnt = 0;
  // Count only cycles in which the pin is driven high
  always @(posedge clk) if (pin_oe === 1'b1 && pin === 1'b1) high_cnt <= high_cnt + 1;
endmodule
`default_nettype wire

// ===== verification/output_compare_pwm_unit_tb.sv
// Register-level tests of the compare channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module output_compare_pwm_unit_tb;
  import ocpwm_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, rd_en = 1'b0, wr_en = 1'b0, idle = 1'b0, fault_req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic wait_req, pin, pin_oe, irq, fa, fb, carry;
  logic [4:0] ticks = 5'h00; // External timers idle except in the cascade and timer one tests
  logic [31:0] syncs = 32'h0;
  logic casc_in = 1'b0;
  logic [15:0] q, q2;
  int high_cnt, irq_cnt = 0, carry_cnt = 0, fail_count = 0, comparisons = 0, h0, i;
  // Settings and expected high counts for the PWM table
  logic [15:0] t_con2 [6] = '{16'h001F, 16'h001F, 16'h101F, 16'h001F, 16'h001F, 16'h003F};
  logic [15:0] t_sec [6] = '{16'h0002, 16'h0001, 16'h0001, 16'h0005, 16'h0000, 16'h0002};
  logic [15:0] t_per [6] = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0000, 16'h0003};
  int t_high [6] = '{20, 10, 30, 40, 0, 0};
  // ****************************************
  // Design and load
  // ****************************************
  ocpwm_channel ocpwm_channel_i (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .timer_tick(ticks), .sync_sources(syncs), .cascade_carry_in(casc_in),
    .cascade_carry_out(carry), .cpu_idle(idle), .fault_pin_a(fa), .fault_pin_b(fb),
    .compare_output_pin(pin), .compare_output_pin_oe(pin_oe), .channel_interrupt_flag(irq));
  ocpwm_load ocpwm_load_i (.clk(clk), .fault_req(fault_req), .pin(pin), .pin_oe(pin_oe),
    .fault_a(fa), .fault_b(fb), .high_cnt(high_cnt));
  // Clock of 10 ns
  initial forever #5 clk = ~clk;
  // Count interrupt pulses
  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // Count carry pulses
  always @(posedge clk) if (carry === 1'b1) carry_cnt <= carry_cnt + 1;
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= {16'h0000, d};
    wr_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    d = rdat[15:0];
    rd_en <= 1'b0;
  endtask
  // Stop the channel so counter clears and duty loads, set values, mode last
  task automatic setup(input logic [15:0] c2, pri, sec, per, c1);
    wr(OFS_CON1, 16'h0000);
    wr(OFS_CON2, c2);
    wr(OFS_PRI, pri);
    wr(OFS_SEC, sec);
    wr(OFS_PER, per);
    wr(OFS_CON1, c1);
  endtask
  // Driven high cycles over a window after settling
  task automatic measure(input int settle, input int n, output int h);
    repeat (settle) @(posedge clk);
    h0 = high_cnt;
    repeat (n) @(posedge clk);
    h = high_cnt - h0;
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog beyond the expected run of about 66600 cycles
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped read
    rd(OFS_CON1, q); `CHK("con1_rst", CON1_RST, q)
    rd(OFS_CON2, q); `CHK("con2_rst", CON2_RST, q)
    rd(8'h20, q); `CHK("unmapped", 16'h0000, q)
    // Disabled channel keeps counter at zero
    wr(OFS_CNT, 16'h1234);
    rd(OFS_CNT, q); `CHK("cnt_off", 16'h0000, q)
    // Edge PWM table: duty, inversion, bounds, tristate
    for (i = 0; i < 6; i++) begin
      setup(t_con2[i], 16'h0000, t_sec[i], t_per[i], 16'h1C06);
      measure(12, 40, h0);
      `CHK("pwm_high", t_high[i], h0)
    end
    // Single compare codes, one match while settling
    for (i = 1; i < 4; i++) begin
      setup(16'h001F, 16'h0005, 16'h0000, 16'hFFFF, 16'h1C00 | i[15:0]);
      q2 = 16'(irq_cnt);
      measure(20, 10, h0);
      `CHK("single_high", (i == 2) ? 0 : 10, h0)
      `CHK("single_irq", 16'h0001, 16'(irq_cnt) - q2)
    end
    // Double compare: one pulse, or a pulse every period
    for (i = 4; i < 6; i++) begin
      setup(16'h001F, 16'h0002, 16'h0004, 16'h0007, 16'h1C00 | i[15:0]);
      measure(0, 40, h0);
      `CHK("double_high", (i == 4) ? 2 : 10, h0)
    end
    // Stop in idle freezes the counter, clear bit lets it run
    idle <= 1'b1;
    setup(16'h001F, 16'h0000, 16'h0000, 16'hFFFF, 16'h3C06);
    rd(OFS_CNT, q);
    rd(OFS_CNT, q2); `CHK("idle_hold", q, q2)
    wr(OFS_CON1, 16'h1C06);
    rd(OFS_CNT, q);
    rd(OFS_CNT, q2); `CHK("idle_run", 1'b1, q2 != q)
    idle <= 1'b0;
    // Trigger mode holds the counter until the selected event
    setup(16'h008B, 16'h0000, 16'h0000, 16'hFFFF, 16'h1C03);
    rd(OFS_CNT, q); `CHK("trig_hold", 16'h0000, q)
    syncs <= 32'h00000800;
    @(posedge clk);
    syncs <= 32'h0;
    rd(OFS_CON2, q); `CHK("trig_set", 16'h00CB, q)
    // Clear mode drops the status on a secondary match
    setup(16'h00CB, 16'h0000, 16'h0010, 16'hFFFF, 16'h1C0B);
    repeat (20) @(posedge clk);
    rd(OFS_CON2, q); `CHK("trig_hw_clr", 16'h008B, q)
    // Cascade carry, then timer one, as the only count pulse
    setup(16'h0100, 16'h0000, 16'h0000, 16'hFFFF, 16'h1C03);
    casc_in <= 1'b1;
    ticks <= 5'h01;
    repeat (3) @(posedge clk);
    casc_in <= 1'b0;
    rd(OFS_CNT, q); `CHK("casc_cnt", 16'h0003, q)
    setup(16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h1003);
    repeat (4) @(posedge clk);
    ticks <= 5'h00;
    rd(OFS_CNT, q); `CHK("tmr_cnt", 16'h0004, q)
    // Free run wraps once and pulses the carry
    setup(16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h1C03);
    repeat (65600) @(posedge clk);
    `CHK("carry", 1, carry_cnt)
    // Fault in center mode drives the fault level and sets status
    // Hold mode, and a forced output while the pin is tristated
    setup(16'hE03F, 16'h0000, 16'h0001, 16'h0003, 16'h1C87);
    fault_req <= 1'b1;
    measure(10, 20, h0);
    `CHK("fault_level", 20, h0)
    rd(OFS_CON1, q); `CHK("fault_stat", 16'h1C97, q)
    fault_req <= 1'b0;
    measure(10, 20, h0);
    `CHK("fault_held", 20, h0)
    wr(OFS_CON1, 16'h1C87);
    measure(10, 20, h0);
    `CHK("fault_clear", 0, h0)
    wrap_up;
  end
endmodule
`default_nettype wire
